/* File: logic/clk_gate_pkg.sv */
// package: register map, field layout and reset values of the clock gate
`default_nettype none
package clk_gate_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [11:0] RUN_GATE_OFF   = 12'h0104;
    localparam logic [11:0] SLEEP_GATE_OFF = 12'h0114;
    localparam logic [11:0] DEEP_GATE_OFF  = 12'h0124;
    localparam logic [11:0] RUN_CFG_OFF    = 12'h0060;
    localparam logic [11:0] IRQ_STAT_OFF   = 12'h0200;
    localparam logic [11:0] IRQ_MASK_OFF   = 12'h0204;
    localparam logic [11:0] FAULT_UNIT_OFF = 12'h0208;
    // ==========================================================
    // gating layout
    localparam int          NUM_UNITS      = 9;
    localparam logic [31:0] GATE_WMASK     = 32'h0707_1013;
    localparam logic [31:0] GATE_RESET     = 32'h0000_0000;
    localparam int          AUTO_GATE_BIT  = 27;
    localparam logic [31:0] RUN_CFG_WMASK  = 32'h0800_0000;
    localparam logic [31:0] RUN_CFG_RESET  = 32'h0000_0000;
    // ==========================================================
    // interrupt status: bit 0 write to gated unit, bit 1 read
    localparam int          IRQ_W          = 2;
    localparam int          IRQ_WR_FAULT   = 0;
    localparam int          IRQ_RD_FAULT   = 1;
    // ==========================================================
    // unit index to gating bit: comparator_two_gate..0, general_counter_two_gate..0, twi, ssp, async_serial_one_gate
    localparam int UNIT_BIT [NUM_UNITS] = '{26, 25, 24, 18, 17, 16, 12, 4, 1};
    localparam int ASYNC_SERIAL_ZERO_GATE_BIT = 0;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_SLEEP,
        MODE_DEEP
    } power_mode_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [3:0]  unit;
    } unit_access_t;
endpackage
`default_nettype wire

/* File: logic/gate_select.sv */
// gate select: picks the active gating word and reports access faults
`timescale 1ns/1ps
`default_nettype none
module gate_select (
    input  wire logic [31:0]           run_gate,   // run-mode gating word
    input  wire logic [31:0]           sleep_gate, // sleep-mode gating word
    input  wire logic [31:0]           deep_gate,  // deep-sleep gating word
    input  wire logic                  auto_gate,  // sleep words in use
    input  wire clk_gate_pkg::power_mode_t mode,   // current power mode
    input  wire clk_gate_pkg::unit_access_t acc,   // peripheral access
    output logic [31:0]                active,     // enables now in force
    output logic                       fault       // access to gated unit
);
    import clk_gate_pkg::*;

    wire [31:0] sleep_sel;
    wire [31:0] deep_sel;
    wire        unit_on;

    // without auto gating the run word rules every mode
    assign sleep_sel = auto_gate ? sleep_gate : run_gate;
    assign deep_sel  = auto_gate ? deep_gate  : run_gate;
    assign active    = (mode == MODE_SLEEP) ? sleep_sel :
                       (mode == MODE_DEEP)  ? deep_sel  : run_gate;
    // units 0..8 mapped to layout bits; 9 is async_serial_zero_gate
    assign unit_on   = (acc.unit == 4'd9) ? active[ASYNC_SERIAL_ZERO_GATE_BIT] :
                       (acc.unit < 4'd9)  ? active[UNIT_BIT[acc.unit]] :
                       1'b0;
    assign fault     = acc.req & ~unit_on;
endmodule
`default_nettype wire

/* File: logic/sleep_mode_peripheral_clock_gate.sv */
// top: apb register file and clock enables for the peripheral gating
//
// Function
// - one writable bit enables one unit
// - bit set: unit receives its clock
// - bit clear: unit clock withheld
// - access to gated unit raises fault
// - register resets to all zeros
// - sleep word applies only in sleep
// - sleep word used only with auto gating
// - bits 18..16 enable timers 2..0
// - bit 12 enables two-wire port
// - bit 4 enables synchronous serial port
// - bits 1,0 enable async serial 1,0
// - reserved bits read as zero
// - spare positions stay inert
// - run mode uses word at 0x104
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_peripheral_clock_gate (
    input  wire logic                       ref_clk,  // 20 MHz clock
    input  wire logic                       resetn,   // sync reset, low
    input  wire logic                       psel,     // apb select
    input  wire logic                       penable,  // apb access phase
    input  wire logic                       pwrite,   // apb write
    input  wire logic [11:0]                paddr,    // apb byte address
    input  wire logic [31:0]                pwdata,   // apb write data
    output logic [31:0]                     prdata,   // apb read data
    output logic                            pready,   // apb ready
    output logic                            pslverr,  // apb error
    input  wire clk_gate_pkg::power_mode_t  mode,     // power mode
    input  wire clk_gate_pkg::unit_access_t unit_acc, // unit bus access
    output logic                            unit_fault, // gated access
    output logic [31:0]                     clk_en,   // per-unit enables
    output logic                            irq       // level interrupt
);
    import clk_gate_pkg::*;

    // ==========================================================
    // registers
    logic [31:0]     run_q, run_d;
    logic [31:0]     sleep_q, sleep_d;
    logic [31:0]     deep_q, deep_d;
    logic [31:0]     cfg_q, cfg_d;
    logic [IRQ_W-1:0] stat_q, stat_d;
    logic [IRQ_W-1:0] mask_q, mask_d;
    logic [3:0]      funit_q, funit_d;
    logic [31:0]     en_q;
    logic            fault_q;
    logic [31:0]     rdata_q;

    // ==========================================================
    // bus decode
    wire        acc_w   = psel & penable & pwrite;
    wire        acc_r   = psel & penable & ~pwrite;
    wire        hit_run = paddr == RUN_GATE_OFF;
    wire        hit_slp = paddr == SLEEP_GATE_OFF;
    wire        hit_dp  = paddr == DEEP_GATE_OFF;
    wire        hit_cfg = paddr == RUN_CFG_OFF;
    wire        hit_st  = paddr == IRQ_STAT_OFF;
    wire        hit_msk = paddr == IRQ_MASK_OFF;
    wire        hit_fu  = paddr == FAULT_UNIT_OFF;
    wire        mapped  = hit_run | hit_slp | hit_dp | hit_cfg |
                          hit_st | hit_msk | hit_fu;
    wire [31:0] gw      = pwdata & GATE_WMASK;
    wire [31:0] active;
    wire        fault_now;
    wire [IRQ_W-1:0] events;

    gate_select u_sel (
        .run_gate   (run_q),
        .sleep_gate (sleep_q),
        .deep_gate  (deep_q),
        .auto_gate  (cfg_q[AUTO_GATE_BIT]),
        .mode       (mode),
        .acc        (unit_acc),
        .active     (active),
        .fault      (fault_now)
    );

    // each writable bit independently gates a unit
    assign run_d   = (acc_w & hit_run) ? gw : run_q;
    assign sleep_d = (acc_w & hit_slp) ? gw : sleep_q;
    assign deep_d  = (acc_w & hit_dp)  ? gw : deep_q;
    assign cfg_d   = (acc_w & hit_cfg) ? (pwdata & RUN_CFG_WMASK) : cfg_q;
    assign mask_d  = (acc_w & hit_msk) ? pwdata[IRQ_W-1:0] : mask_q;
    assign events  = {fault_now & ~unit_acc.write, fault_now & unit_acc.write};
    // set wins over a write-one-to-clear in the same cycle
    assign stat_d  = (stat_q & ~((acc_w & hit_st) ? pwdata[IRQ_W-1:0]
                                                  : {IRQ_W{1'b0}})) | events;
    assign funit_d = fault_now ? unit_acc.unit : funit_q;

    wire [31:0] rmux =
        hit_run ? run_q :
        hit_slp ? sleep_q :
        hit_dp  ? deep_q :
        hit_cfg ? cfg_q :
        hit_st  ? {{(32-IRQ_W){1'b0}}, stat_q} :
        hit_msk ? {{(32-IRQ_W){1'b0}}, mask_q} :
        hit_fu  ? {28'h000_0000, funit_q} : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            run_q   <= GATE_RESET;
            sleep_q <= GATE_RESET;
            deep_q  <= GATE_RESET;
            cfg_q   <= RUN_CFG_RESET;
            stat_q  <= '0;
            mask_q  <= '0;
            funit_q <= 4'h0;
        end else begin
            run_q   <= run_d;
            sleep_q <= sleep_d;
            deep_q  <= deep_d;
            cfg_q   <= cfg_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            funit_q <= funit_d;
        end
    end

    // enables are registered so the gate cells see a glitch-free level
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            en_q    <= GATE_RESET;
            fault_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            en_q    <= active;
            fault_q <= fault_now;
            rdata_q <= (psel & ~penable & ~pwrite) ? rmux : rdata_q;
        end
    end

    assign clk_en     = en_q;
    assign unit_fault = fault_q;
    assign prdata     = rdata_q;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & ~mapped;
    assign irq        = |(stat_q & mask_q);

    // ==========================================================
    // checks
    property p_reset_zero;
        @(posedge ref_clk) $rose(resetn) |-> (sleep_q == 32'h0000_0000 &&
                                             run_q == 32'h0000_0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("gating words not zero after reset");

    property p_reserved_zero;
        @(posedge ref_clk) disable iff (!resetn)
            (sleep_q & ~GATE_WMASK) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved sleep bit set");

    property p_sleep_write;
        @(posedge ref_clk) disable iff (!resetn)
            acc_w && hit_slp |=> sleep_q == $past(pwdata & GATE_WMASK);
    endproperty
    a_sleep_write: assert property (p_sleep_write)
        else $error("sleep word write not stored");

    property p_sleep_used;
        @(posedge ref_clk) disable iff (!resetn)
            mode == MODE_SLEEP && cfg_q[AUTO_GATE_BIT] && $stable(sleep_q)
            |=> clk_en == $past(sleep_q);
    endproperty
    a_sleep_used: assert property (p_sleep_used)
        else $error("sleep enables not applied");

    property p_no_auto;
        @(posedge ref_clk) disable iff (!resetn)
            !cfg_q[AUTO_GATE_BIT] |=> clk_en == $past(run_q);
    endproperty
    a_no_auto: assert property (p_no_auto)
        else $error("run word not used without auto gating");

    property p_fault;
        @(posedge ref_clk) disable iff (!resetn)
            unit_acc.req && unit_acc.unit == 4'd9 && !active[ASYNC_SERIAL_ZERO_GATE_BIT]
            |=> unit_fault;
    endproperty
    a_fault: assert property (p_fault)
        else $error("gated access gave no fault");

    property p_no_fault;
        @(posedge ref_clk) disable iff (!resetn)
            !unit_acc.req |=> !unit_fault;
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("fault without access");

    property p_run_mode;
        @(posedge ref_clk) disable iff (!resetn)
            mode == MODE_RUN |=> clk_en == $past(run_q);
    endproperty
    a_run_mode: assert property (p_run_mode)
        else $error("run word not applied in run mode");

    property p_irq;
        @(posedge ref_clk) disable iff (!resetn)
            fault_now && mask_q[IRQ_WR_FAULT] && unit_acc.write
            && !(acc_w && hit_msk) |=> irq;
    endproperty
    // a mask write in the same cycle may legally drop the enable
    a_irq: assert property (p_irq)
        else $error("masked fault gave no interrupt");

    property p_reset_outs;
        @(posedge ref_clk) $rose(resetn) |->
            (clk_en == 32'h0000_0000 && !irq && !unit_fault);
    endproperty
    a_reset_outs: assert property (p_reset_outs)
        else $error("outputs not idle after reset");

    property p_timer_bits;
        @(posedge ref_clk) disable iff (!resetn)
            acc_w && hit_slp |=> sleep_q[18:16] == $past(pwdata[18:16]);
    endproperty
    a_timer_bits: assert property (p_timer_bits)
        else $error("timer enables not stored");

    property p_two_wire_bit;
        @(posedge ref_clk) disable iff (!resetn)
            acc_w && hit_slp |=> sleep_q[12] == $past(pwdata[12]);
    endproperty
    a_two_wire_bit: assert property (p_two_wire_bit)
        else $error("two-wire enable not stored");

    property p_sync_serial_bit;
        @(posedge ref_clk) disable iff (!resetn)
            acc_w && hit_slp |=> sleep_q[4] == $past(pwdata[4]);
    endproperty
    a_sync_serial_bit: assert property (p_sync_serial_bit)
        else $error("synchronous serial enable not stored");

    property p_async_bits;
        @(posedge ref_clk) disable iff (!resetn)
            acc_w && hit_slp |=> sleep_q[1:0] == $past(pwdata[1:0]);
    endproperty
    a_async_bits: assert property (p_async_bits)
        else $error("async serial enables not stored");

    property p_comp_bits;
        @(posedge ref_clk) disable iff (!resetn)
            acc_w && hit_slp |=> sleep_q[26:24] == $past(pwdata[26:24]);
    endproperty
    a_comp_bits: assert property (p_comp_bits)
        else $error("comparator enables not stored");

    property p_clk_on;
        @(posedge ref_clk) disable iff (!resetn)
            1'b1 |=> (clk_en & $past(active)) == $past(active);
    endproperty
    a_clk_on: assert property (p_clk_on)
        else $error("enabled unit lost its clock");

    property p_clk_off;
        @(posedge ref_clk) disable iff (!resetn)
            1'b1 |=> (clk_en & ~$past(active)) == 32'h0000_0000;
    endproperty
    a_clk_off: assert property (p_clk_off)
        else $error("gated unit still clocked");

    property p_deep_used;
        @(posedge ref_clk) disable iff (!resetn)
            mode == MODE_DEEP && cfg_q[AUTO_GATE_BIT]
            |=> clk_en == $past(deep_q);
    endproperty
    a_deep_used: assert property (p_deep_used)
        else $error("deep-sleep enables not applied");

    property p_stat_sticky;
        @(posedge ref_clk) disable iff (!resetn)
            stat_q[IRQ_WR_FAULT]
            && !(acc_w && hit_st && pwdata[IRQ_WR_FAULT])
            |=> stat_q[IRQ_WR_FAULT];
    endproperty
    a_stat_sticky: assert property (p_stat_sticky)
        else $error("fault status lost without clear");

    property p_fault_unit;
        @(posedge ref_clk) disable iff (!resetn)
            fault_now |=> funit_q == $past(unit_acc.unit);
    endproperty
    a_fault_unit: assert property (p_fault_unit)
        else $error("faulting unit not recorded");

    property p_read_data;
        @(posedge ref_clk) disable iff (!resetn)
            acc_r && hit_slp |-> prdata == sleep_q;
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("sleep word read back wrong");

    property p_spare_inert;
        @(posedge ref_clk) disable iff (!resetn)
            acc_w && !mapped
            |=> $stable(sleep_q) && $stable(run_q) && $stable(cfg_q);
    endproperty
    a_spare_inert: assert property (p_spare_inert)
        else $error("unmapped write changed a register");

    c_deep_apply: cover property (@(posedge ref_clk)
        mode == MODE_DEEP && cfg_q[AUTO_GATE_BIT] && deep_q != 32'h0000_0000);
    c_unit_fault: cover property (@(posedge ref_clk) unit_fault);
    c_sleep_apply: cover property (@(posedge ref_clk)
        mode == MODE_SLEEP && cfg_q[AUTO_GATE_BIT] && sleep_q != 32'h0000_0000);
    c_fault_rd: cover property (@(posedge ref_clk)
        stat_q[IRQ_RD_FAULT]);
    c_irq: cover property (@(posedge ref_clk) irq);
endmodule
`default_nettype wire

/* File: sim/sleep_mode_peripheral_clock_gate_tb_top.sv */
// testbench: apb register, mode selection and unit fault checks
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_peripheral_clock_gate_tb_top;
    import clk_gate_pkg::*;
    logic           ref_clk = 1'b0;
    logic           resetn  = 1'b0;
    logic           psel    = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite  = 1'b0;
    logic [11:0]    paddr   = 12'h000;
    logic [31:0]    pwdata  = 32'h0000_0000;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    power_mode_t    mode    = MODE_RUN;
    unit_access_t   unit_acc = '0;
    logic           unit_fault;
    logic [31:0]    clk_en;
    logic           irq;
    int             err_count = 0;
    int             checked   = 0;
    int             cycles    = 0;
    // gating bit of each unit index; index 10 has no unit
    int             ubit [10] = '{26, 25, 24, 18, 17, 16, 12, 4, 1, 0};

    sleep_mode_peripheral_clock_gate sleep_mode_peripheral_clock_gate_i (
        .ref_clk(ref_clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mode(mode),
        .unit_acc(unit_acc), .unit_fault(unit_fault), .clk_en(clk_en),
        .irq(irq));

    always #25 ref_clk = ~ref_clk;
    // ==========================================================
    // reporting
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // a hang costs one mismatch; the whole run needs well under 2000 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic see(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // ==========================================================
    // bus and port drivers, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        see("pslverr on write", {31'h0, e}, {31'h0, xe});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x,
                      input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        see("prdata", r, x);
        see("pslverr on read", {31'h0, e}, {31'h0, xe});
    endtask

    // settle one more edge so registered outputs reflect their cause
    task automatic outs(input logic [31:0] xen, input logic xirq);
        @(posedge ref_clk);
        @(negedge ref_clk);
        see("clk_en", clk_en, xen);
        see("irq", {31'h0, irq}, {31'h0, xirq});
        @(posedge ref_clk);
    endtask

    task automatic poke(input logic w, input int u, input logic xf);
        unit_acc <= '{req: 1'b1, write: w, unit: u[3:0]};
        @(posedge ref_clk);
        unit_acc <= '0;
        @(negedge ref_clk);
        see("unit_fault", {31'h0, unit_fault}, {31'h0, xf});
        @(posedge ref_clk);
    endtask
    // ==========================================================
    // tests
    initial begin
        logic [31:0] rv;
        logic        re;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rd(SLEEP_GATE_OFF, 32'h0000_0000, 1'b0);
        rd(RUN_GATE_OFF, 32'h0000_0000, 1'b0);
        rd(RUN_CFG_OFF, 32'h0000_0000, 1'b0);
        outs(32'h0000_0000, 1'b0);
        $display("test reset done");
        wr(SLEEP_GATE_OFF, 32'hFFFF_FFFF, 1'b0);
        rd(SLEEP_GATE_OFF, 32'h0707_1013, 1'b0);
        wr(SLEEP_GATE_OFF, 32'h0700_0013, 1'b0);
        rd(SLEEP_GATE_OFF, 32'h0700_0013, 1'b0);
        wr(RUN_CFG_OFF, 32'hFFFF_FFFF, 1'b0);
        rd(RUN_CFG_OFF, 32'h0800_0000, 1'b0);
        $display("test layout done");
        wr(RUN_CFG_OFF, 32'h0000_0000, 1'b0);
        wr(RUN_GATE_OFF, 32'h0000_1000, 1'b0);
        wr(DEEP_GATE_OFF, 32'h0007_0000, 1'b0);
        outs(32'h0000_1000, 1'b0);
        mode <= MODE_SLEEP;
        outs(32'h0000_1000, 1'b0);
        wr(RUN_CFG_OFF, 32'h0800_0000, 1'b0);
        outs(32'h0700_0013, 1'b0);
        mode <= MODE_DEEP;
        outs(32'h0007_0000, 1'b0);
        mode <= MODE_RUN;
        outs(32'h0000_1000, 1'b0);
        $display("test modes done");
        apb(1'b0, SLEEP_GATE_OFF, 32'h0000_0000, rv, re);
        see("pslverr on read", {31'h0, re}, 32'h0000_0000);
        wr(SLEEP_GATE_OFF, rv | 32'h0001_0000, 1'b0);
        rd(SLEEP_GATE_OFF, 32'h0701_0013, 1'b0);
        wr(RUN_GATE_OFF, 32'h0000_0000, 1'b0);
        mode <= MODE_SLEEP;
        for (int u = 0; u < 11; u++) begin
            wr(SLEEP_GATE_OFF, (u < 10) ? (32'h0000_0001 << ubit[u])
                                        : 32'h0000_0000, 1'b0);
            poke(1'b1, u, (u == 10));
            poke(1'b0, (u + 1) % 11, 1'b1);
            rd(FAULT_UNIT_OFF, (u + 1) % 11, 1'b0);
        end
        rd(IRQ_STAT_OFF, 32'h0000_0003, 1'b0);
        outs(32'h0000_0000, 1'b0);
        wr(IRQ_MASK_OFF, 32'h0000_0002, 1'b0);
        outs(32'h0000_0000, 1'b1);
        wr(IRQ_STAT_OFF, 32'h0000_0002, 1'b0);
        rd(IRQ_STAT_OFF, 32'h0000_0001, 1'b0);
        outs(32'h0000_0000, 1'b0);
        wr(IRQ_MASK_OFF, 32'h0000_0003, 1'b0);
        outs(32'h0000_0000, 1'b1);
        wr(IRQ_STAT_OFF, 32'h0000_0001, 1'b0);
        outs(32'h0000_0000, 1'b0);
        poke(1'b1, 10, 1'b1);
        outs(32'h0000_0000, 1'b1);
        $display("test faults done");
        rd(12'h0300, 32'h0000_0000, 1'b1);
        wr(12'h0310, 32'hFFFF_FFFF, 1'b1);
        rd(SLEEP_GATE_OFF, 32'h0000_0000, 1'b0);
        $display("test unmapped done");
        end_of_test();
    end
endmodule
`default_nettype wire
